// ---- frpc_pkg.sv ----
package frpc_pkg;
  // ---------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 10;                   // sys_clk rate in MHz
  localparam int RESET_PULSE_MIN_US = 1;         // Least reset pulse, us
  localparam int RECOVERY_SHORT_US = 20;         // Recovery after non-erase, us
  localparam int RECOVERY_ERASE_MS = 12;         // Recovery after erase, ms
  localparam int POWER_UP_DELAY_US = 100;        // Power-up delay, us
  // Cycle counts derived from the times
  localparam int RESET_PULSE_CYC = (RESET_PULSE_MIN_US * CLK_MHZ < 1) ? 1 : RESET_PULSE_MIN_US * CLK_MHZ;
  localparam int RECOVERY_SHORT_CYC = RECOVERY_SHORT_US * CLK_MHZ;
  localparam int RECOVERY_ERASE_CYC = RECOVERY_ERASE_MS * 1000 * CLK_MHZ;
  localparam int POWER_UP_CYC = POWER_UP_DELAY_US * CLK_MHZ;
  localparam int CNT_W = 24;                     // Width of delay counters

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_RESET_ENABLE = 8'h66; // Arms software reset
  localparam logic [7:0] CMD_RESET = 8'h99;        // Performs software reset
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06; // Sets write enable latch
  localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04; // Clears write enable latch
  localparam logic [7:0] CMD_PROGRAM = 8'h02;      // Starts a program
  localparam logic [7:0] CMD_ERASE = 8'h20;        // Starts an erase
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;  // Returns status byte
  localparam logic [7:0] CMD_LOCK_ALL = 8'h7e;     // Sets volatile lock bits
  localparam logic [7:0] CMD_DEEP_DOWN = 8'hb9;    // Enters deep power-down

  // Status byte fields and default values
  localparam int ST_WIP_BIT = 0;                 // Write-in-progress position
  localparam int ST_WEL_BIT = 1;                 // Write enable latch position
  localparam int ST_LOCK_BIT = 7;                // Any-lock-set position
  localparam int LOCK_W = 8;                     // Number of volatile lock bits
  localparam logic [LOCK_W-1:0] LOCK_DEFAULT = 8'h00; // Power-on lock value

  // Internal operation lengths, cycles
  localparam int PROGRAM_CYC = 200;              // Program busy time
  localparam int ERASE_CYC = 2000;               // Erase busy time

  // Operation being interrupted by reset
  typedef enum logic [1:0] {FRPC_OP_IDLE, FRPC_OP_PROG, FRPC_OP_ERASE} frpc_op_e;
endpackage

// ---- frpc_if.sv ----
`timescale 1ns/1ps
// -----------------------------------------------------------------
// Link between host controller and flash device
// -----------------------------------------------------------------
interface frpc_if;
  logic reset_n;      // Hardware reset, active low
  logic cs_n;         // Chip select, active low
  logic cmd_valid;    // One-cycle command byte strobe
  logic [7:0] cmd;    // Command byte
  logic so_data;      // Serial data out from device
  logic so_oe;        // Device drives serial out
  logic supply_ok;    // Supply above write-inhibit threshold

  modport dev (input reset_n, input cs_n, input cmd_valid, input cmd, input supply_ok,
               output so_data, output so_oe);
  modport host (output reset_n, output cs_n, output cmd_valid, output cmd,
                input so_data, input so_oe, input supply_ok);
endinterface

// ---- frpc_device.sv ----
`timescale 1ns/1ps
module frpc_device
  import frpc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  frpc_if.dev lnk,
  output logic [7:0] status_byte,
  output logic busy,
  output logic deep_down,
  output logic reset_active,
  output logic aborted
);
  import frpc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync_ff;            // Reset pin stages
  logic [1:0] sup_sync_ff;            // Supply-good stages
  logic [1:0] nxt_rst_sync;
  logic [1:0] nxt_sup_sync;
  logic rst_low;                      // Synchronised reset low
  logic sup_ok;                       // Synchronised supply good

  // Next values of the synchronisers
  always_comb begin
    nxt_rst_sync = {rst_sync_ff[0], lnk.reset_n};
    nxt_sup_sync = {sup_sync_ff[0], lnk.supply_ok};
  end

  // Register the synchronisers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rst_sync_ff <= 2'h3;
      sup_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
      sup_sync_ff <= nxt_sup_sync;
    end
  end

  assign rst_low = ~rst_sync_ff[1];
  assign sup_ok = sup_sync_ff[1];

  // ---------------------------------------------------------------
  // Device state
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] pulse_cnt_ff;     // Reset low duration
  logic [CNT_W-1:0] op_cnt_ff;        // Internal operation time left
  logic wel_ff;                       // Write enable latch
  logic reset_armed_ff;               // Reset-enable seen
  logic deep_ff;                      // Deep power-down
  logic aborted_ff;                   // Last reset cut an operation
  logic [LOCK_W-1:0] lock_ff;         // Volatile lock bits
  frpc_op_e op_ff;                    // Operation in progress
  logic [CNT_W-1:0] nxt_pulse_cnt;
  logic [CNT_W-1:0] nxt_op_cnt;
  logic nxt_wel;
  logic nxt_reset_armed;
  logic nxt_deep;
  logic nxt_aborted;
  logic [LOCK_W-1:0] nxt_lock;
  frpc_op_e nxt_op;
  logic full_reset;                   // Any reset of volatile state
  logic cmd_take;                     // Command accepted this cycle

  // Command accepted only when powered, selected, out of reset
  assign cmd_take = lnk.cmd_valid & ~lnk.cs_n & sup_ok & ~rst_low;

  // Next values of all device state
  always_comb begin
    nxt_pulse_cnt = pulse_cnt_ff;
    nxt_op_cnt = op_cnt_ff;
    nxt_wel = wel_ff;
    nxt_reset_armed = reset_armed_ff;
    nxt_deep = deep_ff;
    nxt_aborted = aborted_ff;
    nxt_lock = lock_ff;
    nxt_op = op_ff;
    full_reset = 1'b0;
    // Count reset low time, saturating at the minimum
    if (rst_low) begin
      if (pulse_cnt_ff < CNT_W'(RESET_PULSE_CYC)) begin
        nxt_pulse_cnt = pulse_cnt_ff + CNT_W'(1);
      end
    end else begin
      nxt_pulse_cnt = '0;
    end
    // Internal operation countdown
    if (op_ff != FRPC_OP_IDLE) begin
      if (op_cnt_ff == '0) begin
        nxt_op = FRPC_OP_IDLE;
        nxt_wel = 1'b0;
      end else begin
        nxt_op_cnt = op_cnt_ff - CNT_W'(1);
      end
    end
    // Command decode
    if (cmd_take) begin
      // Any command other than 66h disarms the reset-enable
      nxt_reset_armed = 1'b0;
      if (deep_ff) begin
        // Deep power-down: of the commands, only a software reset pair wakes it
        if (lnk.cmd == CMD_RESET_ENABLE) begin
          nxt_reset_armed = 1'b1;
        end else if (lnk.cmd == CMD_RESET && reset_armed_ff) begin
          full_reset = 1'b1;
        end
      end else begin
        case (lnk.cmd)
          CMD_RESET_ENABLE: begin
            nxt_reset_armed = 1'b1;
          end
          CMD_RESET: begin
            full_reset = reset_armed_ff;
          end
          CMD_WRITE_ENABLE: begin
            if (op_ff == FRPC_OP_IDLE) nxt_wel = 1'b1;
          end
          CMD_WRITE_DISABLE: begin
            if (op_ff == FRPC_OP_IDLE) nxt_wel = 1'b0;
          end
          CMD_LOCK_ALL: begin
            if (op_ff == FRPC_OP_IDLE) nxt_lock = '1;
          end
          CMD_PROGRAM: begin
            if (op_ff == FRPC_OP_IDLE && wel_ff) begin
              nxt_op = FRPC_OP_PROG;
              nxt_op_cnt = CNT_W'(PROGRAM_CYC);
            end
          end
          CMD_ERASE: begin
            if (op_ff == FRPC_OP_IDLE && wel_ff) begin
              nxt_op = FRPC_OP_ERASE;
              nxt_op_cnt = CNT_W'(ERASE_CYC);
            end
          end
          CMD_DEEP_DOWN: begin
            if (op_ff == FRPC_OP_IDLE) nxt_deep = 1'b1;
          end
          default: begin
            nxt_reset_armed = 1'b0;
          end
        endcase
      end
    end
    // Full hardware reset after a long enough pulse
    if (rst_low && pulse_cnt_ff >= CNT_W'(RESET_PULSE_CYC - 1)) begin
      full_reset = 1'b1;
    end
    // Supply below threshold holds everything in reset
    if (!sup_ok) begin
      full_reset = 1'b1;
    end
    if (full_reset) begin
      nxt_aborted = (op_ff != FRPC_OP_IDLE);
      nxt_op = FRPC_OP_IDLE;
      nxt_op_cnt = '0;
      nxt_wel = 1'b0;
      nxt_lock = LOCK_DEFAULT;
      nxt_deep = 1'b0;
      nxt_reset_armed = 1'b0;
    end
  end

  // Register the device state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pulse_cnt_ff <= '0;
      op_cnt_ff <= '0;
      wel_ff <= 1'b0;
      reset_armed_ff <= 1'b0;
      deep_ff <= 1'b0;
      aborted_ff <= 1'b0;
      lock_ff <= LOCK_DEFAULT;
      op_ff <= FRPC_OP_IDLE;
    end else begin
      pulse_cnt_ff <= nxt_pulse_cnt;
      op_cnt_ff <= nxt_op_cnt;
      wel_ff <= nxt_wel;
      reset_armed_ff <= nxt_reset_armed;
      deep_ff <= nxt_deep;
      aborted_ff <= nxt_aborted;
      lock_ff <= nxt_lock;
      op_ff <= nxt_op;
    end
  end

  // ---------------------------------------------------------------
  // Status output
  // ---------------------------------------------------------------
  logic [7:0] status_ff;              // Registered status byte
  logic [7:0] nxt_status;
  logic so_oe_ff;                     // Serial output enable
  logic nxt_so_oe;

  // Build status and output enable
  always_comb begin
    nxt_status = 8'h00;
    nxt_status[ST_WIP_BIT] = (op_ff != FRPC_OP_IDLE);
    nxt_status[ST_WEL_BIT] = wel_ff;
    nxt_status[ST_LOCK_BIT] = |lock_ff;
    // Drive only when selected, powered, not in reset
    nxt_so_oe = ~lnk.cs_n & sup_ok & ~rst_low & ~deep_ff;
  end

  // Register status and enable
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      status_ff <= 8'h00;
      so_oe_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      so_oe_ff <= nxt_so_oe;
    end
  end

  assign lnk.so_oe = so_oe_ff;
  assign lnk.so_data = so_oe_ff & status_ff[ST_WIP_BIT];
  assign status_byte = status_ff;
  assign busy = (op_ff != FRPC_OP_IDLE);
  assign deep_down = deep_ff;
  assign reset_active = rst_low | ~sup_ok;
  assign aborted = aborted_ff;
endmodule

// ---- frpc_host.sv ----
`timescale 1ns/1ps
// Host side: pulses reset, keeps deselect and honours recovery
module frpc_host
  import frpc_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC,
  parameter int RECOVERY_ERASE_CYCLES = RECOVERY_ERASE_CYC
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  frpc_if.host lnk,
  input wire logic hw_reset_req,
  input wire logic sw_reset_req,
  input wire logic cmd_req,
  input wire logic [7:0] cmd_byte,
  input wire logic erase_was_running,
  output logic cmd_ready
);
  import frpc_pkg::*;

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {FRPC_H_POWER, FRPC_H_IDLE, FRPC_H_PULSE, FRPC_H_RECOVER,
                            FRPC_H_SW1, FRPC_H_SW2} frpc_hst_e;
  frpc_hst_e st_ff;                   // Host state
  frpc_hst_e nxt_st;
  logic [CNT_W-1:0] cnt_ff;           // Delay counter
  logic [CNT_W-1:0] nxt_cnt;
  logic [1:0] sup_sync_ff;            // Supply-good stages
  logic [1:0] nxt_sup_sync;
  logic rst_n_ff;                     // Reset pin drive
  logic nxt_rst_n;
  logic cs_n_ff;                      // Chip select drive
  logic nxt_cs_n;
  logic cv_ff;                        // Command strobe
  logic nxt_cv;
  logic [7:0] cmd_ff;                 // Command byte
  logic [7:0] nxt_cmd;

  // Next state of the host
  always_comb begin
    nxt_sup_sync = {sup_sync_ff[0], lnk.supply_ok};
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_rst_n = 1'b1;
    nxt_cs_n = 1'b1;
    nxt_cv = 1'b0;
    nxt_cmd = cmd_ff;
    case (st_ff)
      FRPC_H_POWER: begin
        // Deselected until supply good plus delay
        if (!sup_sync_ff[1]) begin
          nxt_cnt = '0;
        end else if (cnt_ff >= CNT_W'(POWER_UP_CYCLES - 1)) begin
          nxt_st = FRPC_H_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
      end
      FRPC_H_IDLE: begin
        if (hw_reset_req) begin
          nxt_st = FRPC_H_PULSE;
          nxt_cnt = '0;
          nxt_rst_n = 1'b0;
        end else if (sw_reset_req) begin
          nxt_st = FRPC_H_SW1;
          nxt_cs_n = 1'b0;
          nxt_cv = 1'b1;
          nxt_cmd = CMD_RESET_ENABLE;
        end else if (cmd_req) begin
          nxt_cs_n = 1'b0;
          nxt_cv = 1'b1;
          nxt_cmd = cmd_byte;
        end
      end
      FRPC_H_PULSE: begin
        // Hold reset low for the least pulse width
        nxt_rst_n = 1'b0;
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff >= CNT_W'(RESET_PULSE_CYC - 1)) begin
          nxt_rst_n = 1'b1;
          nxt_st = FRPC_H_RECOVER;
          nxt_cnt = erase_was_running ? CNT_W'(RECOVERY_ERASE_CYCLES) : CNT_W'(RECOVERY_SHORT_CYC);
        end
      end
      FRPC_H_RECOVER: begin
        // Wait out the recovery time
        if (cnt_ff == '0) begin
          nxt_st = FRPC_H_IDLE;
        end else begin
          nxt_cnt = cnt_ff - CNT_W'(1);
        end
      end
      FRPC_H_SW1: begin
        // Gap cycle with select released
        nxt_st = FRPC_H_SW2;
      end
      FRPC_H_SW2: begin
        nxt_cs_n = 1'b0;
        nxt_cv = 1'b1;
        nxt_cmd = CMD_RESET;
        nxt_st = FRPC_H_RECOVER;
        nxt_cnt = CNT_W'(RECOVERY_SHORT_CYC);
      end
      default: begin
        nxt_st = FRPC_H_POWER;
      end
    endcase
    // Supply loss forces deselect and restart
    if (!sup_sync_ff[1]) begin
      nxt_st = FRPC_H_POWER;
      nxt_cs_n = 1'b1;
      nxt_cv = 1'b0;
    end
  end

  // Register host state
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_ff <= FRPC_H_POWER;
      cnt_ff <= '0;
      sup_sync_ff <= 2'h0;
      rst_n_ff <= 1'b1;
      cs_n_ff <= 1'b1;
      cv_ff <= 1'b0;
      cmd_ff <= 8'h00;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      sup_sync_ff <= nxt_sup_sync;
      rst_n_ff <= nxt_rst_n;
      cs_n_ff <= nxt_cs_n;
      cv_ff <= nxt_cv;
      cmd_ff <= nxt_cmd;
    end
  end

  assign lnk.reset_n = rst_n_ff;
  assign lnk.cs_n = cs_n_ff;
  assign lnk.cmd_valid = cv_ff;
  assign lnk.cmd = cmd_ff;
  assign cmd_ready = (st_ff == FRPC_H_IDLE) & ~hw_reset_req & ~sw_reset_req;
endmodule

// ---- frpc_checker.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link checker between host and device ends
// ----------------------------------------------------------------
module frpc_checker
  import frpc_pkg::*;
#(
  parameter int POWER_UP_CYCLES = POWER_UP_CYC,
  parameter int RECOVERY_ERASE_CYCLES = RECOVERY_ERASE_CYC
)(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd,
  input wire logic so_data,
  input wire logic so_oe,
  input wire logic supply_ok
);
  // Shorter of the two recovery waits
  localparam int REC_MIN = (RECOVERY_ERASE_CYCLES < RECOVERY_SHORT_CYC) ? RECOVERY_ERASE_CYCLES : RECOVERY_SHORT_CYC;
  int low_cnt; // Cycles reset pin held low
  int rec_cnt; // Cycles since reset pin rose
  int pu_cnt; // Cycles of good supply since start
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  // Helper counters, rec_cnt and pu_cnt saturating
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      low_cnt <= 0;
      rec_cnt <= 1000000;
      pu_cnt <= 0;
    end else begin
      low_cnt <= reset_n ? 0 : low_cnt + 1;
      rec_cnt <= !reset_n ? 0 : ((rec_cnt < 1000000) ? rec_cnt + 1 : rec_cnt);
      // Supply loss restarts the power-up count
      pu_cnt <= !supply_ok ? 0 : ((pu_cnt < POWER_UP_CYCLES) ? pu_cnt + 1 : pu_cnt);
    end
  end
  // Steps of a reset pulse and of a software reset
  sequence s_rst_low;
    $fell(reset_n);
  endsequence
  sequence s_arm;
    cmd_valid && cmd == CMD_RESET_ENABLE;
  endsequence
  sequence s_fire;
    !cmd_valid ##1 (cmd_valid && cmd == CMD_RESET);
  endsequence
  property p_pulse_min;
    $rose(reset_n) |-> low_cnt >= RESET_PULSE_CYC;
  endproperty
  property p_so_float;
    s_rst_low |-> ##5 (!so_oe) [*4];
  endproperty
  property p_cs_reset;
    !reset_n |-> cs_n;
  endproperty
  property p_rec_wait;
    cmd_valid |-> rec_cnt >= REC_MIN;
  endproperty
  property p_pu_wait;
    cmd_valid |-> pu_cnt >= POWER_UP_CYCLES;
  endproperty
  property p_pu_deselect;
    pu_cnt < POWER_UP_CYCLES |-> cs_n;
  endproperty
  property p_supply_float;
    $fell(supply_ok) |-> ##4 (!so_oe) [*3];
  endproperty
  property p_sw_order;
    s_arm |=> s_fire;
  endproperty
  property p_cmd_framed;
    cmd_valid |-> !cs_n && reset_n;
  endproperty
  a_pulse_min: assert property (p_pulse_min) else $error("reset pulse too short");
  a_so_float: assert property (p_so_float) else $error("serial out driven in reset");
  a_cs_reset: assert property (p_cs_reset) else $error("selected during reset");
  a_rec_wait: assert property (p_rec_wait) else $error("command inside recovery");
  a_pu_wait: assert property (p_pu_wait) else $error("command before power-up delay");
  a_pu_deselect: assert property (p_pu_deselect) else $error("selected during power-up");
  a_supply_float: assert property (p_supply_float) else $error("serial out driven at low supply");
  a_sw_order: assert property (p_sw_order) else $error("software reset pair out of order");
  a_cmd_framed: assert property (p_cmd_framed) else $error("command strobe unframed");
endmodule

// ---- test_flash_reset_power_on_control.sv ----
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
// ----------------------------------------------------------------
// Bench joining host and device ends
// ----------------------------------------------------------------
module test_flash_reset_power_on_control;
  import frpc_pkg::*;
  localparam int PU_CYC = 5; // Shortened power-up delay
  localparam int REC_E_CYC = 50; // Shortened erase recovery
  logic sys_clk = 0; // System clock
  logic sys_rst = 1; // Sync reset
  logic hw_reset_req = 0; // Pin reset request
  logic sw_reset_req = 0; // Command reset request
  logic cmd_req = 0; // Command request
  logic [7:0] cmd_byte = 8'h00; // Command to send
  logic erase_was_running = 0; // Picks erase recovery
  logic cmd_ready; // Host idle
  logic [7:0] status_byte; // Device status
  logic busy, deep_down, reset_active, aborted; // Device flags
  int n_mismatch = 0; // Mismatch count
  int total_checks = 0; // Comparison count
  integer seed = 32'h8c1c2432; // Random seed
  logic so_seen; // Serial out enable after a command
  logic so_bit; // Serial out data after a command
  int cyc = 0; // Timeout counter
  int n; // Measured wait
  logic write_enable_latch; // Expected latch
  logic [7:0] c; // Random command
  frpc_if lnk();
  frpc_host #(.POWER_UP_CYCLES(PU_CYC), .RECOVERY_ERASE_CYCLES(REC_E_CYC)) u_frpc_host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(lnk.host), .hw_reset_req(hw_reset_req),
    .sw_reset_req(sw_reset_req), .cmd_req(cmd_req), .cmd_byte(cmd_byte),
    .erase_was_running(erase_was_running), .cmd_ready(cmd_ready));
  frpc_device u_frpc_device (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(lnk.dev), .status_byte(status_byte), .busy(busy),
    .deep_down(deep_down), .reset_active(reset_active), .aborted(aborted));
  frpc_checker #(.POWER_UP_CYCLES(PU_CYC), .RECOVERY_ERASE_CYCLES(REC_E_CYC)) u_frpc_checker (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .reset_n(lnk.reset_n), .cs_n(lnk.cs_n),
    .cmd_valid(lnk.cmd_valid), .cmd(lnk.cmd), .so_data(lnk.so_data), .so_oe(lnk.so_oe),
    .supply_ok(lnk.supply_ok));
  // Clock, 100 ns period
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // Verdict and end of run
  task automatic report_and_stop();
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Expected status from latch and lock
  function automatic logic [7:0] exp_st(input logic w, input logic lk);
    logic [7:0] s;
    s = 8'h00;
    s[ST_WEL_BIT] = w;
    s[ST_LOCK_BIT] = lk;
    return s;
  endfunction
  // Bounded wait at falling edges: 0 ready, 1 pin low, 2 strobe
  task automatic wait_for(input int sel, output int cnt);
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
    end while (cnt < 2000 && !(sel == 0 ? cmd_ready === 1'b1 : (sel == 1 ? lnk.reset_n === 1'b0 :
      lnk.cmd_valid === 1'b1)));
    if (cnt >= 2000) n_mismatch++;
  endtask
  // One command byte, then let the device settle
  task automatic send(input logic [7:0] b);
    int k;
    cmd_byte <= b;
    cmd_req <= 1'b1;
    wait_for(0, k);
    @(posedge sys_clk);
    cmd_req <= 1'b0;
    // Serial out sampled in the cycle after the select
    repeat (2) @(negedge sys_clk);
    so_seen = lnk.so_oe;
    so_bit = lnk.so_data;
    repeat (7) @(posedge sys_clk);
  endtask
  // Pin reset, returns recovery length
  task automatic hw_reset(input logic e, output int rec);
    int k;
    erase_was_running <= e;
    hw_reset_req <= 1'b1;
    wait_for(1, k);
    @(posedge sys_clk);
    hw_reset_req <= 1'b0;
    // Synchronised pin is low two edges later
    repeat (2) @(negedge sys_clk);
    `CHK("reset active", 1'b1, reset_active)
    `CHK("reset float", 1'b0, lnk.so_oe)
    @(posedge lnk.reset_n);
    wait_for(0, rec);
    repeat (4) @(posedge sys_clk);
    `CHK("reset over", 1'b0, reset_active)
  endtask
  // Main sequence
  initial begin
    lnk.supply_ok = 1'b1;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    wait_for(0, n);
    // Power-up state
    `CHK("power status", 8'h00, status_byte)
    `CHK("power deep", 1'b0, deep_down)
    @(posedge sys_clk);
    // Random latch traffic
    write_enable_latch = 1'b0;
    repeat (16) begin
      c = ($random(seed) & 1) ? CMD_WRITE_ENABLE : (($random(seed) & 1) ? CMD_WRITE_DISABLE : CMD_READ_STATUS);
      send(c);
      if (c == CMD_WRITE_ENABLE) write_enable_latch = 1'b1;
      if (c == CMD_WRITE_DISABLE) write_enable_latch = 1'b0;
      `CHK("latch", write_enable_latch, status_byte[ST_WEL_BIT])
    end
    // Locks and latch cleared by pin reset
    send(CMD_WRITE_ENABLE);
    send(CMD_LOCK_ALL);
    `CHK("lock set", 1'b1, status_byte[ST_LOCK_BIT])
    send(CMD_WRITE_ENABLE);
    hw_reset(1'b0, n);
    `CHK("reset status", exp_st(1'b0, 1'b0), status_byte)
    `CHK("short recovery", 1'b1, n >= RECOVERY_SHORT_CYC)
    // Program cut by pin reset
    send(CMD_WRITE_ENABLE);
    send(CMD_PROGRAM);
    send(CMD_READ_STATUS);
    `CHK("out enabled", 1'b1, so_seen)
    `CHK("wip out", 1'b1, so_bit)
    `CHK("program busy", 1'b1, busy)
    hw_reset(1'b0, n);
    `CHK("program abort", 1'b1, aborted)
    `CHK("program idle", 1'b0, busy)
    `CHK("program status", 8'h00, status_byte)
    // Erase cut by pin reset, erase recovery
    send(CMD_WRITE_ENABLE);
    send(CMD_ERASE);
    `CHK("erase wip", 1'b1, status_byte[ST_WIP_BIT])
    hw_reset(1'b1, n);
    `CHK("erase abort", 1'b1, aborted)
    `CHK("erase recovery", 1'b1, n >= REC_E_CYC)
    hw_reset(1'b0, n);
    `CHK("abort cleared", 1'b0, aborted)
    // Deep power-down left by pin reset
    send(CMD_DEEP_DOWN);
    `CHK("deep set", 1'b1, deep_down)
    send(CMD_WRITE_ENABLE);
    `CHK("deep ignores", 8'h00, status_byte)
    hw_reset(1'b0, n);
    `CHK("deep left", 1'b0, deep_down)
    // Lone reset command ignored, pair resets
    send(CMD_WRITE_ENABLE);
    send(CMD_RESET);
    `CHK("lone reset", 1'b1, status_byte[ST_WEL_BIT])
    sw_reset_req <= 1'b1;
    wait_for(2, n);
    @(posedge sys_clk);
    sw_reset_req <= 1'b0;
    wait_for(0, n);
    repeat (8) @(posedge sys_clk);
    `CHK("soft reset", 8'h00, status_byte)
    // Supply drop clears state
    send(CMD_WRITE_ENABLE);
    lnk.supply_ok <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("low supply", 8'h00, status_byte)
    `CHK("low supply hold", 1'b1, reset_active)
    lnk.supply_ok <= 1'b1;
    send(CMD_READ_STATUS);
    `CHK("supply back", 8'h00, status_byte)
    report_and_stop();
  end
endmodule
